// ---- design/eqs_scheduler.sv ----
/*
 * eqs_scheduler: picks the traffic-class queue that sends the next frame on the
 * port, with strict priority, weighted round robin or deficit round robin, and a
 * configurable count of strict-priority classes at the top.
 * assumes: queue status and frame length come from logic on mclk; the mac pulses
 * frame_done once per granted frame; config inputs are held steady by the caller.
 */
`timescale 1ns/1ps

module eqs_scheduler #(
    parameter int unsigned SUBQ = 2
) (
    input  wire logic                                    mclk,
    input  wire logic                                    rst,
    input  wire logic                                    clk_en,
    input  wire logic [eqs_pkg::CLASS_COUNT*SUBQ-1:0]    queue_ready,
    input  wire logic [eqs_pkg::LEN_W-1:0]               frame_len,
    input  wire logic                                    frame_done,
    input  wire eqs_pkg::eqs_mode_type                   sched_mode,
    input  wire logic [eqs_pkg::SP_COUNT_W-1:0]          sp_count,
    input  wire logic [eqs_pkg::CLASS_COUNT*eqs_pkg::WEIGHT_W-1:0] class_weight,
    output logic                                         grant_valid,
    output logic [eqs_pkg::CLASS_W-1:0]                  grant_class,
    output logic [$clog2(SUBQ > 1 ? SUBQ : 2)-1:0]       grant_subq,
    output logic [eqs_pkg::CLASS_COUNT-1:0]              class_is_strict,
    output logic [eqs_pkg::CLASS_W-1:0]                  rr_pointer
);
    localparam int unsigned NC = eqs_pkg::CLASS_COUNT;
    localparam int unsigned SW = $clog2(SUBQ > 1 ? SUBQ : 2);
    localparam int unsigned DW = eqs_pkg::DEFICIT_W;

    eqs_pkg::eqs_state_type state;
    eqs_pkg::eqs_state_type next_state;

    logic signed [DW-1:0] deficit [NC];
    logic [SW-1:0]        subq_ptr [NC];
    logic [NC-1:0]        class_busy;
    logic [NC-1:0]        strict_busy;
    logic [NC-1:0]        rr_busy;
    logic                 sp_hit;
    logic [2:0]           sp_pick;
    logic                 rr_hit;
    logic [2:0]           rr_pick;
    logic [2:0]           pick_class;
    logic [SW-1:0]        pick_subq;
    logic                 rr_need_new;
    logic                 cur_from_rr;
    logic signed [DW-1:0] rr_quantum;
    logic signed [DW-1:0] rr_credit;
    logic                 rr_skip;
    logic                 grant_go;
    logic signed [DW-1:0] len_ext;

    // class c is strict when it lies among the sp_count highest classes
    // strict level of class c is sp_count-(7-c); rr slot is c (ordering equals class order)
    genvar g;
    generate
        for (g = 0; g < NC; g = g + 1) begin : g_cls
            assign class_busy[g]      = |queue_ready[g*SUBQ +: SUBQ];
            assign class_is_strict[g] = ({1'b0, sp_count} + 5'(g)) >= 5'(NC);
            assign strict_busy[g]     = class_busy[g] & class_is_strict[g];
            assign rr_busy[g]         = class_busy[g] & ~class_is_strict[g];
        end
    endgenerate

    function automatic logic [2:0] top_set(input logic [NC-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < NC; i++) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // highest strict class wins every pick
    assign sp_hit  = |strict_busy;
    assign sp_pick = top_set(strict_busy);

    // scan downward from the pointer over busy rr classes, wrapping to the top
    logic [NC-1:0] rr_below;
    generate
        for (g = 0; g < NC; g = g + 1) begin : g_below
            assign rr_below[g] = rr_busy[g] && (3'(g) <= rr_pointer);
        end
    endgenerate
    assign rr_hit  = |rr_busy;
    assign rr_pick = (|rr_below) ? top_set(rr_below) : top_set(rr_busy);

    // the pointed class keeps sending while its credit stays positive
    assign rr_need_new = !rr_busy[rr_pointer] || (deficit[rr_pointer] <= 0);

    assign pick_class = sp_hit ? sp_pick : rr_pick;

    // rotate among the physical queues of the chosen class
    function automatic logic [SW-1:0] next_subq(input logic [SUBQ-1:0] rdy, input logic [SW-1:0] start);
        logic [SW-1:0] r;
        logic          found;
        r = start;
        found = 1'b0;
        for (int k = 0; k < SUBQ; k++) begin
            if (!found && rdy[(int'(start) + k) % SUBQ]) begin
                r = SW'((int'(start) + k) % SUBQ);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    assign pick_subq = next_subq(queue_ready[pick_class*SUBQ +: SUBQ], subq_ptr[pick_class]);

    // one grant per frame, none while all queues are empty
    always_comb begin
        next_state = state;
        unique case (state)
            eqs_pkg::EQS_IDLE: begin
                if (|class_busy) begin
                    next_state = eqs_pkg::EQS_PICK;
                end
            end
            eqs_pkg::EQS_PICK: begin
                next_state = grant_go ? eqs_pkg::EQS_SEND : eqs_pkg::EQS_IDLE;
            end
            eqs_pkg::EQS_SEND: begin
                if (frame_done) begin
                    next_state = eqs_pkg::EQS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= eqs_pkg::EQS_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // grant latched at pick time and held until the frame completes
    always_ff @(posedge mclk) begin
        if (rst) begin
            grant_valid <= 1'b0;
            grant_class <= '0;
            grant_subq  <= '0;
            cur_from_rr <= 1'b0;
        end else if (clk_en) begin
            if (grant_go) begin
                grant_valid <= 1'b1;
                grant_class <= pick_class;
                grant_subq  <= pick_subq;
                cur_from_rr <= !sp_hit;
            end else if (state == eqs_pkg::EQS_SEND && frame_done) begin
                grant_valid <= 1'b0;
            end
        end
    end

    // quantum per class from its weight
    function automatic logic signed [DW-1:0] quantum(input logic [eqs_pkg::WEIGHT_W-1:0] w);
        return DW'(w) * DW'(eqs_pkg::QUANTUM_UNIT);
    endfunction

    // credit the picked class starts its visit with; wrr drops unused credit, deficit mode keeps it
    assign rr_quantum = quantum(class_weight[rr_pick*eqs_pkg::WEIGHT_W +: eqs_pkg::WEIGHT_W]);
    assign rr_credit  = (sched_mode == eqs_pkg::EQS_MODE_WRR && deficit[rr_pick] > 0)
        ? rr_quantum : deficit[rr_pick] + rr_quantum;
    // a class still in debt after its top-up gives up the visit
    // a zero weight is never skipped so it cannot stall the port
    assign rr_skip  = !sp_hit && rr_need_new && (rr_credit <= 0) && (rr_quantum > 0);
    assign grant_go = (state == eqs_pkg::EQS_PICK) && (|class_busy) && !rr_skip;
    // frame length as a signed count so a debt compares correctly
    assign len_ext  = DW'(frame_len);

    always_ff @(posedge mclk) begin
        if (rst) begin
            rr_pointer <= eqs_pkg::RR_POINTER_RESET;
            for (int c = 0; c < NC; c++) begin
                deficit[c]  <= eqs_pkg::DEFICIT_RESET;
                subq_ptr[c] <= '0;
            end
        end else if (clk_en) begin
            if (state == eqs_pkg::EQS_PICK && (|class_busy)) begin
                if (grant_go) begin
                    subq_ptr[pick_class] <= SW'((int'(pick_subq) + 1) % SUBQ);
                end
                // rr credit is touched only when no strict queue waits
                if (!sp_hit && rr_need_new) begin
                    // a skipped class hands the visit to the next lower class, 0 wraps to 7
                    rr_pointer       <= rr_skip ? rr_pick - 3'h1 : rr_pick;
                    deficit[rr_pick] <= rr_credit;
                end
            end else if (state == eqs_pkg::EQS_SEND && frame_done && cur_from_rr) begin
                deficit[grant_class] <= deficit[grant_class] - len_ext;
                // move on when the credit is spent; an empty class forgets unused credit
                if (deficit[grant_class] <= len_ext && grant_class != 3'h0) begin
                    rr_pointer <= grant_class - 3'h1;
                end else if (deficit[grant_class] <= len_ext) begin
                    rr_pointer <= 3'h7;
                end
            end else if (!rr_busy[rr_pointer] && deficit[rr_pointer] > 0) begin
                deficit[rr_pointer] <= eqs_pkg::DEFICIT_RESET;
            end
        end
    end

endmodule

// ---- design/eqs_pkg.sv ----
/*
 * eqs_pkg: shared constants and types for the egress queue scheduler.
 * assumes: a single mclk domain; users reference everything as eqs_pkg::name.
 */
package eqs_pkg;
    localparam int unsigned CLASS_COUNT  = 8;
    localparam int unsigned CLASS_W      = 3;
    localparam int unsigned SP_COUNT_W   = 4;
    localparam int unsigned WEIGHT_W     = 8;
    localparam int unsigned LEN_W        = 16;
    // deficit counter carries a sign bit so overuse can be remembered
    localparam int unsigned DEFICIT_W    = 24;
    localparam int unsigned QUANTUM_UNIT = 64;   // bytes of allocation per unit of weight
    localparam logic [DEFICIT_W-1:0] DEFICIT_RESET = 24'h000000;
    localparam logic [3:0]           SP_COUNT_RESET = 4'h0;
    // round robin starts its first round at the top class
    localparam logic [2:0]           RR_POINTER_RESET = 3'h7;

    typedef enum logic [1:0] {
        EQS_MODE_SP,
        EQS_MODE_WRR,
        EQS_MODE_DWRR
    } eqs_mode_type;

    typedef enum logic [1:0] {
        EQS_IDLE,
        EQS_PICK,
        EQS_SEND
    } eqs_state_type;
endpackage

// ---- tb/eqs_mac_model.sv ----
/* eqs_mac_model: port transmit side that ends each granted frame.
   assumes grant_valid comes from the scheduler on mclk. */
`timescale 1ns/1ps
module eqs_mac_model (
    input  wire logic        mclk,
    input  wire logic        grant_valid,
    input  wire logic [15:0] len,
    input  wire logic [3:0]  wait_cycles,
    output logic             frame_done,
    output logic [15:0]      frame_len
);
    logic [3:0] cnt = 4'h0;
    initial frame_done = 1'b0;
    // length is scrambled outside the done pulse so it is never read stale
    assign frame_len = frame_done ? len : ~len;
    always @(posedge mclk) begin
        #1;
        if (grant_valid && !frame_done && cnt == wait_cycles) begin
            frame_done = 1'b1;
            cnt = 4'h0;
        end else begin
            frame_done = 1'b0;
            cnt = grant_valid ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ---- tb/eqs_sched_assertions.sv ----
/* eqs_sched_assertions: port checks of the scheduler.
   assumes a bind from the bench and one mclk domain. */
`timescale 1ns/1ps
module eqs_sched_assertions #(
    parameter int unsigned SUBQ = 2
) (
    input wire logic                                 mclk,
    input wire logic                                 rst,
    input wire logic                                 clk_en,
    input wire logic [eqs_pkg::CLASS_COUNT*SUBQ-1:0] queue_ready,
    input wire logic                                 frame_done,
    input wire logic [eqs_pkg::SP_COUNT_W-1:0]       sp_count,
    input wire logic                                 grant_valid,
    input wire logic [eqs_pkg::CLASS_W-1:0]          grant_class,
    input wire logic [$clog2(SUBQ > 1 ? SUBQ : 2)-1:0] grant_subq,
    input wire logic [eqs_pkg::CLASS_COUNT-1:0]      class_is_strict,
    input wire logic [eqs_pkg::CLASS_W-1:0]          rr_pointer
);
    logic [7:0] any_q;
    logic [7:0] str_q;
    logic [7:0] exp_s;
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            any_q[c] = |queue_ready[c*SUBQ +: SUBQ];
            exp_s[c] = (sp_count + c) >= 8;
        end
    end
    assign str_q = any_q & class_is_strict;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence rise_s;
        $rose(grant_valid);
    endsequence
    strict_map_a:
        assert property (class_is_strict == exp_s) else $error("strict map");
    no_empty_a:
        assert property (rise_s |-> $past(queue_ready, 2) != 0) else $error("grant with no frame");
    grant_hold_a:
        assert property (grant_valid && !frame_done |=> grant_valid && $stable(grant_class)
            && $stable(grant_subq)) else $error("grant moved mid frame");
    done_drop_a:
        assert property (grant_valid && frame_done && clk_en |=> !grant_valid) else $error("grant kept");
    grant_gap_a:
        assert property ($fell(grant_valid) |-> !grant_valid [*2]) else $error("grant too soon");
    ready_queue_a:
        assert property (rise_s |-> (($past(queue_ready) >> (grant_class*SUBQ + grant_subq)) & 1) != 0)
            else $error("granted queue empty");
    strict_top_a:
        assert property (rise_s and $past(str_q) != 0 |-> ($past(str_q) >> grant_class) == 8'h01)
            else $error("strict order");
    rr_only_a:
        assert property (rise_s and $past(str_q) == 0 |-> !class_is_strict[grant_class])
            else $error("strict class in round robin");
    freeze_a:
        assert property (!clk_en |=> $stable(grant_valid) && $stable(rr_pointer)) else $error("not frozen");
endmodule

// ---- tb/tb_top.sv ----
/* tb_top: scenario bench for the egress queue scheduler.
   assumes the mac model and the checker are compiled before it. */
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned SUBQ = 2;
    logic                  mclk, rst, clk_en, frame_done, grant_valid, grant_subq, gs;
    logic [15:0]           queue_ready, frame_len, mac_len;
    logic [3:0]            sp_count, mac_wait;
    logic [63:0]           class_weight;
    logic [2:0]            grant_class, rr_pointer, gc;
    logic [7:0]            class_is_strict;
    eqs_pkg::eqs_mode_type sched_mode;
    int                    errors = 0;
    int                    total_checks = 0;
    eqs_scheduler #(.SUBQ(SUBQ)) dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .queue_ready(queue_ready),
        .frame_len(frame_len), .frame_done(frame_done), .sched_mode(sched_mode), .sp_count(sp_count),
        .class_weight(class_weight), .grant_valid(grant_valid), .grant_class(grant_class),
        .grant_subq(grant_subq), .class_is_strict(class_is_strict), .rr_pointer(rr_pointer));
    eqs_mac_model mac (.mclk(mclk), .grant_valid(grant_valid), .len(mac_len), .wait_cycles(mac_wait),
        .frame_done(frame_done), .frame_len(frame_len));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic grab;
        int n = 0;
        while (grant_valid !== 1'b1 && n < 300) @(posedge mclk) #1 n++;
        chk("grant seen", 8'h01, {7'h0, grant_valid});
        gc = grant_class;
        gs = grant_subq;
        while (grant_valid === 1'b1 && n < 300) @(posedge mclk) #1 n++;
        chk("grant end", 8'h00, {7'h0, grant_valid});
    endtask
    task automatic t_empty;
        repeat (10) @(posedge mclk);
        #1;
        chk("idle grant", 8'h00, {7'h0, grant_valid});
        chk("reset pointer", {5'h0, eqs_pkg::RR_POINTER_RESET}, {5'h0, rr_pointer});
    endtask
    task automatic t_strict;
        sp_count = 4'h8;
        queue_ready = 16'h0410;
        repeat (3) begin
            grab();
            chk("strict class", 8'h05, {5'h0, gc});
        end
        queue_ready = 16'h0010;
        grab();
        chk("lower class", 8'h02, {5'h0, gc});
    endtask
    task automatic t_subq;
        queue_ready = 16'h0300;
        mac_wait = 4'h8;
        grab();
        gs = ~gs;
        repeat (3) @(posedge mclk);
        #1 clk_en = 1'b0;
        repeat (3) @(posedge mclk);
        #1 clk_en = 1'b1;
        chk("next subq", {7'h0, gs}, {7'h0, grant_subq});
        grab();
        mac_wait = 4'h0;
    endtask
    task automatic t_hybrid;
        int n3 = 0;
        sched_mode = eqs_pkg::EQS_MODE_WRR;
        sp_count = 4'h2;
        queue_ready = 16'h1044;
        grab();
        chk("strict first", 8'h06, {5'h0, gc});
        chk("strict map", 8'hc0, class_is_strict);
        queue_ready = 16'h0044;
        grab();
        chk("rr start", 8'h03, {5'h0, gc});
        chk("rr pointer", 8'h02, {5'h0, rr_pointer});
        repeat (4) begin
            grab();
            n3 += (gc === 3'h3);
        end
        chk("rr share", 8'h02, n3[7:0]);
    endtask
    task automatic t_dwrr;
        int n3 = 0;
        sched_mode = eqs_pkg::EQS_MODE_DWRR;
        sp_count = 4'h0;
        class_weight = 64'h01010101_02010101;
        mac_len = 16'h0060;
        repeat (30) begin
            grab();
            n3 += (gc === 3'h3);
        end
        chk("dwrr share", 8'h01, {7'h0, n3 >= 18 && n3 <= 22});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        queue_ready = 16'h0000;
        mac_len = 16'h0040;
        mac_wait = 4'h0;
        sp_count = 4'h0;
        class_weight = 64'h01010101_01010101;
        sched_mode = eqs_pkg::EQS_MODE_SP;
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        t_empty();
        t_strict();
        t_subq();
        t_hybrid();
        t_dwrr();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        results();
    end
endmodule
bind eqs_scheduler eqs_sched_assertions #(.SUBQ(SUBQ)) chk_i (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .queue_ready(queue_ready), .frame_done(frame_done), .sp_count(sp_count), .grant_valid(grant_valid),
    .grant_class(grant_class), .grant_subq(grant_subq), .class_is_strict(class_is_strict),
    .rr_pointer(rr_pointer));
